// file: core/result_bank_regs.svh
// Register offsets, field positions, reset values and codes of the result register bank.
`ifndef RESULT_BANK_REGS_SVH
`define RESULT_BANK_REGS_SVH

// ==========================================================================
// Offsets (byte addresses)
`define ADC_RAW_RESULT_OFS       16'h2074
`define DFT_REAL_RESULT_OFS      16'h2078
`define DFT_IMAG_RESULT_OFS      16'h207C
`define NOTCH_FILTER_RESULT_OFS  16'h2080
`define TEMPERATURE_RESULT_OFS   16'h2084
`define TRANSFORM_CONFIG_OFS     16'h20D0
`define ADC_FILTER_CONFIG_OFS    16'h2044
`define IRQ_FLAGS_A_OFS          16'h3010
`define IRQ_FLAGS_B_OFS          16'h3014
`define IRQ_MASK_OFS             16'h3018

// ==========================================================================
// Fields
`define INSEL_MSB                21
`define INSEL_LSB                20
`define POINTS_MSB               7
`define POINTS_LSB               4
`define WINDOW_EN_BIT            0
`define AVG_EN_BIT               7
`define BYPASS3_BIT              6
`define NOTCH_BYP_BIT            4
`define RATE_BIT                 0
`define NOTCH_IRQ_BIT            2
`define IRQ_ADC_BIT              0
`define IRQ_DFT_BIT              1
`define IRQ_TEMP_BIT             3

// ==========================================================================
// Reset values and write masks
`define TRANSFORM_CONFIG_RST     32'h0000_0090
`define TRANSFORM_CONFIG_WMASK   32'h0030_00F1
`define ADC_FILTER_CONFIG_WMASK  32'h0000_00D1
`define IRQ_WMASK                32'h0000_000F
`define POINTS_MAX_CODE          4'hC

`endif

// file: core/result_bank_pkg.sv
// Types shared by the result register bank.
package result_bank_pkg;

  typedef enum logic [1:0] {
    SRC_SINC2   = 2'b00,
    SRC_GAINOFS = 2'b01,
    SRC_RAW     = 2'b10,
    SRC_SINC2B  = 2'b11
  } dft_src_t;

  typedef enum logic [2:0] {
    FEED_SINC2   = 3'b000,
    FEED_GO_RAW  = 3'b001,
    FEED_GO_SINC3 = 3'b010,
    FEED_RAW     = 3'b011,
    FEED_AVERAGE = 3'b100
  } dft_feed_t;

  typedef struct packed {
    logic [15:0] adc_raw;
    logic [17:0] dft_real;
    logic [17:0] dft_imag;
    logic [15:0] notch;
    logic [15:0] temp;
    logic [31:0] xcfg;
    logic [31:0] fcfg;
    logic [3:0]  flags_a;
    logic [3:0]  flags_b;
    logic [3:0]  mask;
    logic [31:0] rdata;
    logic        rvalid;
  } bank_state_t;

endpackage

// file: core/adc_dft_result_registers.sv
// Result register bank with DFT input selection and interrupt flags.
//
// Behaviour
// - Raw result holds 16-bit unsigned ADC data; upper bits read zero.
// - Raw result loads unfiltered data with sinc3 bypassed, else sinc2 when it has a sample and notch is used, else sinc3.
// - Real DFT part sits in bits 17..0 as 18-bit twos complement.
// - Imaginary DFT part sits in bits 17..0 as 18-bit twos complement.
// - Notch result holds the 50/60 Hz rejection filter output in low 16 bits.
// - New notch result sets bit 2 in both interrupt flag registers.
// - Temperature result holds the temperature channel result in low 16 bits.
// - Input select codes 00 and 11 route sinc2 output to the DFT.
// - Averaging enable feeds the average output regardless of input select.
// - Select 01 with sinc3 bypassed feeds corrected raw data.
// - Select 01 with sinc3 active feeds corrected sinc3 output.
// - Select 10 feeds uncorrected ADC output directly.
// - Averaging enabled switches DFT source to the average output automatically.
// - Sinc3 bypass passes raw samples straight to gain and offset stage.
// - Sample rate bit: 1 means 800 kHz, 0 means 1.6 MHz.
// - Point count field gives 4 times two to the code, resets to 9.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "result_bank_regs.svh"

module adc_dft_result_registers
  import result_bank_pkg::*;
#(
  parameter int ADC_W = 16,
  parameter int DFT_W = 18
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // Avalon-MM slave
  input  wire logic [15:0]       address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  // Converter and filter streams
  input  wire logic [ADC_W-1:0]  raw_data,
  input  wire logic              raw_valid,
  input  wire logic [ADC_W-1:0]  sinc3_data,
  input  wire logic              sinc3_valid,
  input  wire logic [ADC_W-1:0]  gainofs_data,
  input  wire logic              gainofs_valid,
  input  wire logic [ADC_W-1:0]  sinc2_data,
  input  wire logic              sinc2_valid,
  input  wire logic [ADC_W-1:0]  notch_data,
  input  wire logic              notch_valid,
  input  wire logic [ADC_W-1:0]  average_data,
  input  wire logic              average_valid,
  input  wire logic [ADC_W-1:0]  temp_data,
  input  wire logic              temp_valid,
  // Transform engine
  input  wire logic [DFT_W-1:0]  dft_real_in,
  input  wire logic [DFT_W-1:0]  dft_imag_in,
  input  wire logic              dft_done,
  output logic [ADC_W-1:0]       dft_in_data,
  output logic                   dft_in_valid,
  output logic [2:0]             dft_feed,
  output logic [3:0]             transform_point_count,
  output logic                   window_enable,
  output logic                   third_order_filter_bypass,
  output logic                   sample_rate_select,
  // Interrupt
  output logic                   irq
);

  // ==========================================================================
  // State
  bank_state_t st_reg;
  bank_state_t st_next;
  dft_feed_t   feed;
  logic [ADC_W-1:0] adc_sel;
  logic             adc_sel_v;
  logic [31:0]      wmask;
  logic [3:0]       ev;

  // ==========================================================================
  // Source selection
  always_comb begin
    feed = FEED_SINC2;
    if (st_reg.fcfg[`AVG_EN_BIT]) begin
      feed = FEED_AVERAGE;
    end else begin
      unique case (dft_src_t'(st_reg.xcfg[`INSEL_MSB:`INSEL_LSB]))
        SRC_SINC2, SRC_SINC2B: feed = FEED_SINC2;
        SRC_GAINOFS: feed = st_reg.fcfg[`BYPASS3_BIT] ? FEED_GO_RAW
                                                      : FEED_GO_SINC3;
        SRC_RAW: feed = FEED_RAW;
      endcase
    end
  end

  // Gain and offset stage already sees raw or sinc3 depending on the bypass
  // bit, so both corrected choices take the same stream here.
  always_comb begin
    unique case (feed)
      FEED_AVERAGE: begin
        dft_in_data  = average_data;
        dft_in_valid = average_valid;
      end
      FEED_GO_RAW, FEED_GO_SINC3: begin
        dft_in_data  = gainofs_data;
        dft_in_valid = gainofs_valid;
      end
      FEED_RAW: begin
        dft_in_data  = raw_data;
        dft_in_valid = raw_valid;
      end
      default: begin
        dft_in_data  = sinc2_data;
        dft_in_valid = sinc2_valid;
      end
    endcase
  end

  // Raw result source: sinc2 when it has a sample and the notch path is used with sinc3 active, else sinc3 or raw.
  always_comb begin
    if (!st_reg.fcfg[`BYPASS3_BIT] && sinc2_valid && !st_reg.fcfg[`NOTCH_BYP_BIT]) begin
      adc_sel   = sinc2_data;
      adc_sel_v = 1'b1;
    end else if (!st_reg.fcfg[`BYPASS3_BIT]) begin
      adc_sel   = sinc3_data;
      adc_sel_v = sinc3_valid;
    end else begin
      adc_sel   = raw_data;
      adc_sel_v = raw_valid;
    end
  end

  assign dft_feed                  = feed;
  assign transform_point_count     = st_reg.xcfg[`POINTS_MSB:`POINTS_LSB];
  assign window_enable             = st_reg.xcfg[`WINDOW_EN_BIT];
  assign third_order_filter_bypass = st_reg.fcfg[`BYPASS3_BIT];
  assign sample_rate_select        = st_reg.fcfg[`RATE_BIT];
  assign readdata                  = st_reg.rdata;
  // Reads answer one cycle after they are taken; writes are taken at once.
  assign waitrequest               = read && !st_reg.rvalid;
  assign irq                       = |((st_reg.flags_a | st_reg.flags_b) & st_reg.mask);

  // ==========================================================================
  // Register update
  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    ev = 4'h0;
    if (adc_sel_v) begin
      st_next.adc_raw = adc_sel;
      ev[`IRQ_ADC_BIT] = 1'b1;
    end
    if (dft_done) begin
      st_next.dft_real = dft_real_in;
      st_next.dft_imag = dft_imag_in;
      ev[`IRQ_DFT_BIT] = 1'b1;
    end
    if (notch_valid) begin
      st_next.notch = notch_data;
      ev[`NOTCH_IRQ_BIT] = 1'b1;
    end
    if (temp_valid) begin
      st_next.temp = temp_data;
      ev[`IRQ_TEMP_BIT] = 1'b1;
    end
    if (write) begin
      unique case (address)
        `TRANSFORM_CONFIG_OFS: begin
          st_next.xcfg = (st_reg.xcfg & ~(wmask & `TRANSFORM_CONFIG_WMASK))
                       | (writedata & wmask & `TRANSFORM_CONFIG_WMASK);
          if (st_next.xcfg[`POINTS_MSB:`POINTS_LSB] > `POINTS_MAX_CODE) begin
            st_next.xcfg[`POINTS_MSB:`POINTS_LSB] = `POINTS_MAX_CODE;
          end
        end
        `ADC_FILTER_CONFIG_OFS: begin
          st_next.fcfg = (st_reg.fcfg & ~(wmask & `ADC_FILTER_CONFIG_WMASK))
                       | (writedata & wmask & `ADC_FILTER_CONFIG_WMASK);
        end
        `IRQ_FLAGS_A_OFS: st_next.flags_a = st_reg.flags_a & ~(writedata[3:0] & wmask[3:0]);
        `IRQ_FLAGS_B_OFS: st_next.flags_b = st_reg.flags_b & ~(writedata[3:0] & wmask[3:0]);
        `IRQ_MASK_OFS: begin
          if (byteenable[0]) begin
            st_next.mask = writedata[3:0];
          end
        end
        default: ;
      endcase
    end
    // Events are applied after the clear so that a set in the same cycle wins.
    st_next.flags_a = st_next.flags_a | ev;
    st_next.flags_b = st_next.flags_b | ev;
    if (read && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      unique case (address)
        `ADC_RAW_RESULT_OFS:      st_next.rdata = {16'h0000, st_reg.adc_raw};
        `DFT_REAL_RESULT_OFS:     st_next.rdata = {14'h0000, st_reg.dft_real};
        `DFT_IMAG_RESULT_OFS:     st_next.rdata = {14'h0000, st_reg.dft_imag};
        `NOTCH_FILTER_RESULT_OFS: st_next.rdata = {16'h0000, st_reg.notch};
        `TEMPERATURE_RESULT_OFS:  st_next.rdata = {16'h0000, st_reg.temp};
        `TRANSFORM_CONFIG_OFS:    st_next.rdata = st_reg.xcfg;
        `ADC_FILTER_CONFIG_OFS:   st_next.rdata = st_reg.fcfg;
        `IRQ_FLAGS_A_OFS:         st_next.rdata = {28'h0000000, st_reg.flags_a};
        `IRQ_FLAGS_B_OFS:         st_next.rdata = {28'h0000000, st_reg.flags_b};
        `IRQ_MASK_OFS:            st_next.rdata = {28'h0000000, st_reg.mask};
        default:                  st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg      <= '0;
      st_reg.xcfg <= `TRANSFORM_CONFIG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // adc_dft_result_registers

// file: verif/adc_dft_result_registers_assertions.sv
// Concurrent checks on the ports of the result register bank.
`timescale 1ns/1ps
module adc_dft_result_registers_chk (
  // Clock and bus
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  // Transform feed
  input wire logic [2:0]  dft_feed,
  input wire logic [15:0] dft_in_data,
  input wire logic        dft_in_valid,
  input wire logic [15:0] raw_data,
  input wire logic [15:0] gainofs_data,
  input wire logic [15:0] sinc2_data,
  input wire logic        sinc2_valid,
  input wire logic [15:0] average_data,
  input wire logic        third_order_filter_bypass,
  input wire logic [3:0]  transform_point_count,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Feed selection, bus timing and interrupt
  a_feed_sinc2: assert property (dft_feed == 3'h0 |->
    dft_in_data == sinc2_data && dft_in_valid == sinc2_valid) else $error("sinc2 feed");
  a_feed_average: assert property (dft_feed == 3'h4 |->
    dft_in_data == average_data) else $error("average feed");
  a_feed_corrected: assert property (dft_feed inside {3'h1, 3'h2} |->
    dft_in_data == gainofs_data) else $error("corrected feed");
  a_feed_uncorrected: assert property (dft_feed == 3'h3 |->
    dft_in_data == raw_data) else $error("raw feed");
  a_bypass_path: assert property (dft_feed == 3'h1 |-> third_order_filter_bypass)
    else $error("bypass feed without bypass");
  a_sinc3_path: assert property (dft_feed == 3'h2 |-> !third_order_filter_bypass)
    else $error("sinc3 feed while bypassed");
  a_points_limit: assert property (transform_point_count <= 4'hC)
    else $error("point count above limit");
  a_read_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read answer timing");
  a_write_nowait: assert property (write |-> !waitrequest)
    else $error("write stalled");
  a_irq_clear: assert property ($fell(irq) |-> $past(write))
    else $error("irq dropped without software");
  c_avg: cover property (dft_feed == 3'h4);
  c_raw: cover property (dft_feed == 3'h3);
  c_irq: cover property ($fell(irq));
endmodule // adc_dft_result_registers_chk

bind adc_dft_result_registers adc_dft_result_registers_chk chk_u (.*);

// file: verif/tb_adc_dft_result_registers.sv
// Self-checking bench for the result register bank.
`timescale 1ns/1ps
`include "result_bank_regs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module tb_adc_dft_result_registers;
  import result_bank_pkg::*;
  logic        mclk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, waitrequest, irq;
  logic [15:0] address = 16'h0, dft_in_data;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [3:0]  byteenable = 4'hF, transform_point_count;
  logic [15:0] raw_data = 16'h1111, sinc3_data = 16'h2222, gainofs_data = 16'h3333;
  logic [15:0] sinc2_data = 16'h4444, notch_data = 16'h5555, average_data = 16'h6666;
  logic [15:0] temp_data = 16'h7777;
  logic [15:0] fd [0:4] = '{16'h4444, 16'h3333, 16'h3333, 16'h1111, 16'h6666};
  logic [17:0] dft_real_in = 18'h2ABCD, dft_imag_in = 18'h12345;
  logic [7:0]  vld = 8'h00;
  logic        raw_valid, sinc3_valid, gainofs_valid, sinc2_valid, notch_valid;
  logic        average_valid, temp_valid, dft_done, dft_in_valid, window_enable;
  logic        third_order_filter_bypass, sample_rate_select;
  logic [2:0]  dft_feed, e;
  int          error_cnt = 0, num_checks = 0;
  assign {raw_valid, sinc3_valid, gainofs_valid, sinc2_valid, notch_valid, average_valid,
          temp_valid, dft_done} = vld;

  adc_dft_result_registers dut_u (.*);

  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // ==========================================================================
  // Bus access and stream tasks
  task automatic acc(input bit wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    logic w;
    n = 0;
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    // Look at the answer mid-cycle, where it is settled, then take it at the next edge.
    do begin
      @(negedge mclk);
      w = waitrequest;
      q = readdata;
      @(posedge mclk);
      n++;
    end while (w !== 1'b0 && n < 40);
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 40) error_cnt++;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input string s);
    acc(1'b0, a, 32'h0);
    `CHK(s, x, q)
  endtask
  task automatic pulse(input logic [7:0] m);
    vld <= m;
    @(posedge mclk);
    vld <= 8'h00;
    @(posedge mclk);
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) rd(16'h2074 + 16'(4 * i), 32'h0, "result");
    rd(`TRANSFORM_CONFIG_OFS, 32'h0000_0090, "xcfg");
    `CHK("points", 4'h9, transform_point_count)
    rd(16'h2000, 32'h0, "unmapped");
    acc(1'b1, `IRQ_MASK_OFS, 32'hF);
    pulse(8'h08);
    rd(`IRQ_FLAGS_A_OFS, 32'h4, "flags_a");
    rd(`IRQ_FLAGS_B_OFS, 32'h4, "flags_b");
    `CHK("irq", 1'b1, irq)
    acc(1'b1, `IRQ_FLAGS_A_OFS, 32'hF);
    acc(1'b1, `IRQ_FLAGS_B_OFS, 32'hF);
    `CHK("irq", 1'b0, irq)
    pulse(8'hFF);
    rd(`ADC_RAW_RESULT_OFS, 32'h4444, "raw");
    rd(`DFT_REAL_RESULT_OFS, 32'h0002_ABCD, "real");
    rd(`DFT_IMAG_RESULT_OFS, 32'h0001_2345, "imag");
    rd(`NOTCH_FILTER_RESULT_OFS, 32'h5555, "notch");
    rd(`TEMPERATURE_RESULT_OFS, 32'h7777, "temp");
    acc(1'b1, `ADC_RAW_RESULT_OFS, 32'hFFFF_FFFF);
    rd(`ADC_RAW_RESULT_OFS, 32'h4444, "raw_ro");
    acc(1'b1, `TRANSFORM_CONFIG_OFS, 32'hFFFF_FFFF);
    rd(`TRANSFORM_CONFIG_OFS, 32'h0030_00C1, "xcfg_max");
    `CHK("window", 1'b1, window_enable)
    acc(1'b1, `ADC_FILTER_CONFIG_OFS, 32'h41);
    pulse(8'h80);
    rd(`ADC_RAW_RESULT_OFS, 32'h1111, "raw_byp");
    acc(1'b1, `ADC_FILTER_CONFIG_OFS, 32'h10);
    pulse(8'h40);
    rd(`ADC_RAW_RESULT_OFS, 32'h2222, "raw_s3");
    // Raw selection is only ever paired with the 800 kHz rate.
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, `TRANSFORM_CONFIG_OFS, {10'h0, i[1:0], 20'h00090});
      acc(1'b1, `ADC_FILTER_CONFIG_OFS, {24'h0, i[3], i[2], 5'h0, i[1]});
      e = i[3] ? 3'h4 : i[1:0] == 2'h2 ? 3'h3 : i[1:0] == 2'h1 ? (i[2] ? 3'h1 : 3'h2) : 3'h0;
      `CHK("feed", e, dft_feed)
      `CHK("feed_data", fd[e], dft_in_data)
      `CHK("bypass", i[2], third_order_filter_bypass)
      `CHK("rate", i[1], sample_rate_select)
    end
    conclude();
  end
endmodule // tb_adc_dft_result_registers
